// [shared/smrc_consts.vh]
`ifndef SMRC_CONSTS_VH
`define SMRC_CONSTS_VH

// Register indices and their byte addresses (four bytes per index).
`define SMRC_CTRL_INDEX      8'hff
`define SMRC_RESET_SOURCE_REGISTER_INDEX    8'hef
`define SMRC_CTRL_ADDR       12'h3fc
`define SMRC_RESET_SOURCE_REGISTER_ADDR     12'h3bc
`define SMRC_ADDR_W          12

// Supply monitor control fields.
`define SMRC_CTRL_EN_BIT     7
`define SMRC_CTRL_RSTOK_BIT  6
`define SMRC_CTRL_WARN_BIT   5
`define SMRC_CTRL_BAT_BIT    4
`define SMRC_CTRL_WIE_BIT    3
`define SMRC_CTRL_BIE_BIT    2
`define SMRC_CTRL_EN_RST     1'b1
`define SMRC_CTRL_WIE_RST    1'b1
`define SMRC_CTRL_BIE_RST    1'b0

// Reset source fields.
`define SMRC_RS_FERR_BIT     6
`define SMRC_RS_SW_BIT       4
`define SMRC_RS_POR_BIT      1
`define SMRC_RS_PIN_BIT      0
`define SMRC_RS_SEL_RST      1'b1

// Length of a software or flash-error reset pulse, in clock cycles.
`define SMRC_PULSE_CYCLES    4'd8

`endif

// [hw/smrc_supply_monitor.v]
// Summary of operation
// - Power-on and power-fail resets leave the monitor enabled and selected.
// - Enabled, selected monitor with low supply drives pin low, holds reset.
// - After power-fail the power flag reads one and RAM is invalid.
// - Only power-on and power-fail resets alter monitor enable and select.
// - Power-fail reset is disabled while the device sleeps.
// - On wake the enable and select set by software apply again.
// - Early-warning bit clears below warning threshold and can interrupt.
// - Flash erase or write with monitor disabled causes flash-error reset.
// - Control bit 7 enables the monitor, resets to one.
// - Bit 6 reads live supply against reset threshold.
// - Bit 5 reads live supply against warning threshold.
// - Bit 4 reads battery warning comparison on battery variants.
// - Bit 3 enables core warning interrupt on battery variants (fixed at one otherwise), resets to one.
// - Bit 2 enables battery warning interrupt, resets to zero.
// - Control bits 1 and 0 read zero and ignore writes.
// - Low reset pin forces a device reset, even during sleep.
// - Leaving a pin reset sets reset-source bit 0.
// - Reset-source index 0xef; bit 1 writes select or deselect monitor.
// - Writing one to reset-source bit 4 forces a software reset.
`timescale 1ns/10ps
`include "smrc_consts.vh"

module smrc_supply_monitor #(
  parameter HAS_BATTERY = 1
) (
  // APB slave.
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Analog comparators, high while the supply is above the threshold.
  input  wire        cmp_core_above_reset,
  input  wire        cmp_core_above_warn,
  input  wire        cmp_bat_above_warn,
  // Power mode and flash activity.
  input  wire        sleep_active,
  input  wire        flash_write_attempt,
  // Active-low reset pin, open drain.
  input  wire        rst_pin_n_in,
  output reg         rst_pin_out,
  output reg         rst_pin_oe,
  // Reset and status to the rest of the chip.
  output reg         sys_reset_n,
  output reg         ram_invalid,
  output reg         core_warning_irq,
  output reg         battery_warning_irq
);

  localparam ST_RUN     = 2'd0;
  localparam ST_PF_HOLD = 2'd1;
  localparam ST_PIN     = 2'd2;
  localparam ST_PULSE   = 2'd3;

  // Comparator synchronisers.
  reg  [2:0] cmp_meta_reg;
  reg  [2:0] cmp_sync_reg;
  wire       core_ok_rst;
  wire       core_ok_warn;
  wire       bat_ok_warn;

  // Retained monitor settings and control bits.
  reg        monitor_enable_reg;
  reg        monitor_select_reg;
  reg        core_warning_irq_enable_reg;
  reg        battery_warning_irq_enable_reg;

  // Reset cause flags and sequencer.
  reg        power_fail_flag_reg;
  reg        pin_reset_flag_reg;
  reg        software_reset_flag_reg;
  reg        flash_error_flag_reg;
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [3:0] pulse_cnt_reg;
  reg        pulse_is_sw_reg;

  wire       wr_access;
  wire       ctrl_hit;
  wire       rs_hit;
  wire       pf_trip;
  wire       sw_force;
  wire       flash_err;
  wire       core_ie_eff;
  wire       bat_ie_eff;
  wire [7:0] ctrl_value;
  wire [7:0] rs_value;

  function decode_hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      decode_hit = (addr == target);
    end
  endfunction

  assign ctrl_hit  = decode_hit(paddr, `SMRC_CTRL_ADDR);
  assign rs_hit    = decode_hit(paddr, `SMRC_RESET_SOURCE_REGISTER_ADDR);
  assign wr_access = psel & penable & pready & pwrite;

  assign core_ok_rst  = cmp_sync_reg[0];
  assign core_ok_warn = cmp_sync_reg[1];
  assign bat_ok_warn  = (HAS_BATTERY != 0) ? cmp_sync_reg[2] : 1'b1;

  assign core_ie_eff = (HAS_BATTERY != 0) ?
                       core_warning_irq_enable_reg : 1'b1;
  assign bat_ie_eff  = (HAS_BATTERY != 0) ?
                       battery_warning_irq_enable_reg : 1'b0;

  // Sleep gates the trip only; the retained settings stay untouched.
  assign pf_trip = monitor_enable_reg & monitor_select_reg &
                   ~sleep_active & ~core_ok_rst;
  assign sw_force = wr_access & rs_hit &
                    pwdata[`SMRC_RS_SW_BIT];
  assign flash_err = flash_write_attempt & ~monitor_enable_reg;

  assign ctrl_value = {monitor_enable_reg,
                       core_ok_rst,
                       core_ok_warn,
                       bat_ok_warn & (HAS_BATTERY != 0),
                       core_ie_eff,
                       bat_ie_eff,
                       2'b00};
  assign rs_value = {1'b0,
                     flash_error_flag_reg,
                     1'b0,
                     software_reset_flag_reg,
                     2'b00,
                     power_fail_flag_reg,
                     pin_reset_flag_reg};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Start at the healthy level so that the release of reset does not
      // look like a supply dip and start a spurious power-fail hold.
      cmp_meta_reg <= 3'h7;
      cmp_sync_reg <= 3'h7;
    end else begin
      cmp_meta_reg <= {cmp_bat_above_warn, cmp_core_above_warn,
                       cmp_core_above_reset};
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // APB answer: one wait-free access cycle after every setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~ctrl_hit & ~rs_hit;
      if (psel & ~penable & ~pwrite) begin
        if (ctrl_hit) begin
          prdata <= {24'h0, ctrl_value};
        end else if (rs_hit) begin
          prdata <= {24'h0, rs_value};
        end else begin
          prdata <= 32'h0;
        end
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // Monitor settings: these flops keep their value through sleep and
  // software resets; power-on restores them all, power-fail only enable and select.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_enable_reg <= `SMRC_CTRL_EN_RST;
      monitor_select_reg <= `SMRC_RS_SEL_RST;
      core_warning_irq_enable_reg    <= `SMRC_CTRL_WIE_RST;
      battery_warning_irq_enable_reg <= `SMRC_CTRL_BIE_RST;
    end else if (pf_trip) begin
      monitor_enable_reg <= 1'b1;
      monitor_select_reg <= 1'b1;
    end else if (wr_access) begin
      if (ctrl_hit) begin
        monitor_enable_reg <= pwdata[`SMRC_CTRL_EN_BIT];
        core_warning_irq_enable_reg <= pwdata[`SMRC_CTRL_WIE_BIT];
        battery_warning_irq_enable_reg <= pwdata[`SMRC_CTRL_BIE_BIT];
      end
      if (rs_hit) begin
        monitor_select_reg <= pwdata[`SMRC_RS_POR_BIT];
      end
    end
  end

  // Reset sequencer.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (pf_trip) begin
          state_next = ST_PF_HOLD;
        end else if (!rst_pin_n_in) begin
          state_next = ST_PIN;
        end else if (sw_force | flash_err) begin
          state_next = ST_PULSE;
        end
      end
      ST_PF_HOLD: begin
        if (core_ok_rst) begin
          state_next = ST_RUN;
        end
      end
      ST_PIN: begin
        if (pf_trip) begin
          state_next = ST_PF_HOLD;
        end else if (rst_pin_n_in) begin
          state_next = ST_RUN;
        end
      end
      ST_PULSE: begin
        if (pf_trip) begin
          state_next = ST_PF_HOLD;
        end else if (!rst_pin_n_in) begin
          state_next = ST_PIN;
        end else if (pulse_cnt_reg == 4'h1) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_RUN;
      pulse_cnt_reg   <= 4'h0;
      pulse_is_sw_reg <= 1'b0;
      sys_reset_n     <= 1'b0;
      rst_pin_out     <= 1'b0;
      rst_pin_oe      <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RUN && state_next == ST_PULSE) begin
        pulse_cnt_reg   <= `SMRC_PULSE_CYCLES;
        pulse_is_sw_reg <= sw_force;
      end else if (pulse_cnt_reg != 4'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
      end
      sys_reset_n <= (state_next == ST_RUN);
      rst_pin_out <= 1'b0;
      rst_pin_oe  <= (state_next == ST_PF_HOLD);
    end
  end

  // Cause flags describe the last reset and are set as it ends.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_fail_flag_reg     <= 1'b1;
      pin_reset_flag_reg      <= 1'b0;
      software_reset_flag_reg <= 1'b0;
      flash_error_flag_reg    <= 1'b0;
      ram_invalid             <= 1'b1;
    end else if (state_reg != ST_RUN && state_next == ST_RUN) begin
      power_fail_flag_reg     <= (state_reg == ST_PF_HOLD);
      pin_reset_flag_reg      <= (state_reg == ST_PIN);
      software_reset_flag_reg <= (state_reg == ST_PULSE) &
                                 pulse_is_sw_reg;
      flash_error_flag_reg    <= (state_reg == ST_PULSE) &
                                 ~pulse_is_sw_reg;
      ram_invalid             <= (state_reg == ST_PF_HOLD);
    end
  end

  // Warning interrupt requests, live levels gated by their enables.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_warning_irq    <= 1'b0;
      battery_warning_irq <= 1'b0;
    end else begin
      core_warning_irq    <= ~core_ok_warn & core_ie_eff;
      battery_warning_irq <= ~bat_ok_warn & bat_ie_eff;
    end
  end

endmodule // smrc_supply_monitor

// [tb/smrc_supply_monitor_assertions.sv]
`timescale 1ns/10ps
`include "smrc_consts.vh"
module smrc_supply_monitor_assertions (
  // Bus side.
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Supply, pin and reset side.
  input wire        cmp_core_above_reset,
  input wire        cmp_core_above_warn,
  input wire        cmp_bat_above_warn,
  input wire        sleep_active,
  input wire        rst_pin_n_in,
  input wire        rst_pin_out,
  input wire        rst_pin_oe,
  input wire        sys_reset_n,
  input wire        core_warning_irq,
  input wire        battery_warning_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ctrl = pready && !pwrite && paddr == `SMRC_CTRL_ADDR;
  AST_PIN_HOLDS: assert property (!rst_pin_n_in && !rst_pin_oe |=> !sys_reset_n)
    else $error("pin low without core reset");
  AST_PIN_DRIVE: assert property (rst_pin_oe |-> !sys_reset_n && !rst_pin_out)
    else $error("pin driven outside a held reset");
  AST_SLEEP: assert property ($past(sleep_active) |-> !$rose(rst_pin_oe))
    else $error("power fail trip during sleep");
  AST_WARN_IRQ: assert property (cmp_core_above_warn[*5] |-> !core_warning_irq)
    else $error("core warning irq with supply good");
  AST_BAT_IRQ: assert property (cmp_bat_above_warn[*5] |-> !battery_warning_irq)
    else $error("battery irq with battery good");
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNUSED: assert property (rd_ctrl |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("unused control bits not zero");
  AST_STATUS: assert property (cmp_core_above_reset[*5] ##0 rd_ctrl |-> prdata[6])
    else $error("reset status bit wrong");
  AST_WARN_STAT: assert property (!cmp_core_above_warn[*5] ##0 rd_ctrl |-> !prdata[5])
    else $error("warning status bit wrong");
  cover property ($fell(sys_reset_n));
  cover property ($rose(rst_pin_oe));
  cover property (pslverr);
endmodule // smrc_supply_monitor_assertions
bind smrc_supply_monitor smrc_supply_monitor_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmp_core_above_reset(cmp_core_above_reset),
  .cmp_core_above_warn(cmp_core_above_warn),
  .cmp_bat_above_warn(cmp_bat_above_warn), .sleep_active(sleep_active),
  .rst_pin_n_in(rst_pin_n_in), .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe), .sys_reset_n(sys_reset_n),
  .core_warning_irq(core_warning_irq),
  .battery_warning_irq(battery_warning_irq));

// [tb/smrc_far_side.sv]
`timescale 1ns/10ps
module smrc_far_side (
  // Supply levels and pin pull from the bench.
  input  wire core_ok,
  input  wire warn_ok,
  input  wire bat_ok,
  input  wire ext_low,
  // Device pin driver.
  input  wire oe,
  input  wire out,
  // Comparators and pin level.
  output wire cmp_r,
  output wire cmp_w,
  output wire cmp_b,
  output wire rst_pin_n
);
  assign cmp_r = core_ok;
  assign cmp_w = warn_ok;
  assign cmp_b = bat_ok;
  // The pin has a pull-up; the bench pull or an enabled driver with a low output pulls it low.
  assign rst_pin_n = !(ext_low || (oe && !out));
endmodule // smrc_far_side

// [tb/smrc_supply_monitor_tb.sv]
`timescale 1ns/10ps
`include "smrc_consts.vh"
module smrc_supply_monitor_tb;
  reg         pclk, presetn, psel, penable, pwrite, sleep_active, flash_req;
  reg         core_ok, warn_ok, bat_ok, ext_low, errv;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdv;
  wire [31:0] prdata;
  wire        pready, pslverr, cmp_r, cmp_w, cmp_b, rst_pin_n, pin_out;
  wire        pin_oe, sys_reset_n, ram_invalid, core_irq, bat_irq;
  integer     bad_count, samples_checked;
  localparam [11:0] C = `SMRC_CTRL_ADDR;
  localparam [11:0] RS = `SMRC_RESET_SOURCE_REGISTER_ADDR;
  smrc_supply_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_core_above_reset(cmp_r), .cmp_core_above_warn(cmp_w),
    .cmp_bat_above_warn(cmp_b), .sleep_active(sleep_active),
    .flash_write_attempt(flash_req), .rst_pin_n_in(rst_pin_n),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .sys_reset_n(sys_reset_n),
    .ram_invalid(ram_invalid), .core_warning_irq(core_irq),
    .battery_warning_irq(bat_irq));
  smrc_far_side far (.core_ok(core_ok), .warn_ok(warn_ok), .bat_ok(bat_ok),
    .ext_low(ext_low), .oe(pin_oe), .out(pin_out), .cmp_r(cmp_r),
    .cmp_w(cmp_w), .cmp_b(cmp_b), .rst_pin_n(rst_pin_n));
  task close_out;
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready at a rising edge, then releases.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n = n + 1; end
    while (pready !== 1'b1 && n < 20);
    rdv = prdata; errv = pslverr; psel <= 1'b0; penable <= 1'b0;
    if (n == 20) begin bad_count = bad_count + 1; close_out; end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0); chk(rdv, e);
  endtask
  task wt(input v);
    integer n;
    n = 0;
    do begin @(posedge pclk); n = n + 1; end
    while (sys_reset_n !== v && n < 60);
    if (n == 60) begin bad_count = bad_count + 1; close_out; end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sleep_active = 0; flash_req = 0; core_ok = 1; warn_ok = 1; bat_ok = 1;
    ext_low = 0; bad_count = 0; samples_checked = 0; rdv = 0; errv = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(C, 32'hf8);
    rd(RS, 32'h02); chk(ram_invalid, 1);
    apb(1, C, 32'hff); rd(C, 32'hfc);
    apb(0, 12'h000, 0); chk({errv, rdv[7:0]}, 9'h100);
    warn_ok <= 0; bat_ok <= 0; repeat (6) @(posedge pclk);
    chk({core_irq, bat_irq}, 2'h3);
    rd(C, 32'hcc);
    apb(1, C, 32'h80); repeat (3) @(posedge pclk);
    chk({core_irq, bat_irq}, 2'h0);
    warn_ok <= 1; bat_ok <= 1; sleep_active <= 1; ext_low <= 1; wt(0);
    repeat (4) @(posedge pclk);
    ext_low <= 0; wt(1); sleep_active <= 0;
    rd(RS, 32'h01); chk(ram_invalid, 0);
    apb(1, C, 32'h08); apb(1, RS, 32'h00); apb(1, RS, 32'h10); wt(0); wt(1);
    rd(RS, 32'h10); rd(C, 32'h78);
    core_ok <= 0; repeat (8) @(posedge pclk); chk(sys_reset_n, 1);
    core_ok <= 1; flash_req <= 1; @(posedge pclk);
    flash_req <= 0; wt(0); wt(1); rd(RS, 32'h40);
    apb(1, C, 32'h88); apb(1, RS, 32'h02);
    sleep_active <= 1; core_ok <= 0; repeat (10) @(posedge pclk);
    chk(sys_reset_n, 1);
    sleep_active <= 0; wt(0); chk(pin_oe, 1);
    core_ok <= 1; wt(1); rd(RS, 32'h02); chk(ram_invalid, 1);
    rd(C, 32'hf8);
    close_out;
  end
endmodule // smrc_supply_monitor_tb
